/* common/acsm_params.svh */
// constants for the link status, modem slot and queue level block
// assumes a 32-bit register bus and the 256-bit serial link frame
`ifndef ACSM_PARAMS_SVH
`define ACSM_PARAMS_SVH

// ==========================================================
// register offsets (byte addresses)
`define ACSM_OFS_CMD 8'h20
`define ACSM_OFS_STAT 8'h24
`define ACSM_OFS_MCTL 8'h28
`define ACSM_OFS_MSTAT 8'h2c
`define ACSM_OFS_LEVEL 8'h30
`define ACSM_OFS_INT_ST 8'h3c
`define ACSM_OFS_INT_MSK 8'h40

// ==========================================================
// field positions
`define ACSM_CMD_GO_BIT 24
`define ACSM_CMD_RW_BIT 7
`define ACSM_MCTL_GO_BIT 20
`define ACSM_LVL_RX_PURGE_BIT 31
`define ACSM_LVL_TX_PURGE_BIT 30
`define ACSM_TAG_READY_BIT 15
`define ACSM_TAG_S1_BIT 14
`define ACSM_TAG_S2_BIT 13
`define ACSM_TAG_S12_BIT 3

// ==========================================================
// reset values
`define ACSM_RX_FILL_RST 8'h00
`define ACSM_TX_FREE_RST 8'h80
`define ACSM_POS_RST 8'hff

// ==========================================================
// frame layout, in bit positions within the frame
`define ACSM_TAG_LAST 8'd15
`define ACSM_S1_FIRST 8'd16
`define ACSM_S1_LAST 8'd35
`define ACSM_S2_FIRST 8'd36
`define ACSM_S2_LAST 8'd55
`define ACSM_S12_FIRST 8'd236
`define ACSM_S12_LAST 8'd255

`endif

/* common/acsm_pkg.sv */
// types shared by the link status and modem slot block
// assumes acsm_params.svh for all numeric constants
`default_nettype none
package acsm_pkg;
  typedef logic [31:0] acsm_word_t;
  typedef logic [19:0] acsm_slot_t;
  typedef logic [2:0] acsm_irq_t;
  typedef enum logic [2:0] {
    ACSM_BUS_IDLE = 3'b001,
    ACSM_BUS_WRITE = 3'b010,
    ACSM_BUS_READ = 3'b100
  } acsm_bus_state_t;
endpackage
`default_nettype wire

/* common/acsm_link_if.sv */
// frame content passed between the core and its serialiser/deserialiser
// assumes all users run on the one system clock
`default_nettype none
interface acsm_link_if;
  import acsm_pkg::*;
  logic [7:0] tx_pos;
  logic tx_cmd_go;
  logic tx_rw;
  logic [6:0] tx_index;
  logic [15:0] tx_wdata;
  logic tx_modem_go;
  acsm_slot_t tx_modem;
  logic tx_bit;
  logic rx_fall;
  logic [7:0] rx_pos;
  logic rx_bit;
  logic rx_done;
  logic [15:0] rx_tag;
  acsm_slot_t rx_slot1;
  acsm_slot_t rx_slot2;
  acsm_slot_t rx_slot12;
  modport core(output tx_pos, tx_cmd_go, tx_rw, tx_index, tx_wdata, tx_modem_go, tx_modem,
    input tx_bit, output rx_fall, rx_pos, rx_bit, input rx_done, rx_tag, rx_slot1, rx_slot2, rx_slot12);
  modport tx(input tx_pos, tx_cmd_go, tx_rw, tx_index, tx_wdata, tx_modem_go, tx_modem, output tx_bit);
  modport rx(input rx_fall, rx_pos, rx_bit, output rx_done, rx_tag, rx_slot1, rx_slot2, rx_slot12);
endinterface
`default_nettype wire

/* rtl/acsm_frame_tx.sv */
// picks the outgoing serial bit for a frame position
// assumes the core latches the frame content at frame start
`include "acsm_params.svh"
`default_nettype none
module acsm_frame_tx (
  // frame content and position
  acsm_link_if.tx lk
);
  import acsm_pkg::*;
  // ==========================================================
  // slot words
  wire [15:0] tag_word;
  wire [19:0] s1_word;
  wire [19:0] s2_word;
  wire [7:0] i_tag;
  wire [7:0] i_s1;
  wire [7:0] i_s2;
  wire [7:0] i_s12;
  wire in_tag;
  wire in_s1;
  wire in_s2;
  wire in_s12;
  assign tag_word = {lk.tx_cmd_go | lk.tx_modem_go, lk.tx_cmd_go, lk.tx_cmd_go & ~lk.tx_rw, 9'h000,
                     lk.tx_modem_go, 3'h0};
  assign s1_word = {lk.tx_rw, lk.tx_index, 12'h000};
  assign s2_word = {lk.tx_wdata, 4'h0};
  // ==========================================================
  // position decode
  assign i_tag = `ACSM_TAG_LAST - lk.tx_pos;
  assign i_s1 = `ACSM_S1_LAST - lk.tx_pos;
  assign i_s2 = `ACSM_S2_LAST - lk.tx_pos;
  assign i_s12 = `ACSM_S12_LAST - lk.tx_pos;
  assign in_tag = lk.tx_pos <= `ACSM_TAG_LAST;
  assign in_s1 = lk.tx_pos >= `ACSM_S1_FIRST && lk.tx_pos <= `ACSM_S1_LAST;
  assign in_s2 = lk.tx_pos >= `ACSM_S2_FIRST && lk.tx_pos <= `ACSM_S2_LAST;
  assign in_s12 = lk.tx_pos >= `ACSM_S12_FIRST;
  assign lk.tx_bit = in_tag ? tag_word[i_tag[3:0]] :
                     (in_s1 && lk.tx_cmd_go) ? s1_word[i_s1[4:0]] :
                     (in_s2 && lk.tx_cmd_go && !lk.tx_rw) ? s2_word[i_s2[4:0]] :
                     (in_s12 && lk.tx_modem_go) ? lk.tx_modem[i_s12[4:0]] :
                     1'b0;
endmodule
`default_nettype wire

/* rtl/acsm_frame_rx.sv */
// collects tag, slots 1, 2 and 12 from the incoming serial stream
// assumes rx_fall marks a synchronised falling edge of the link clock
`include "acsm_params.svh"
`default_nettype none
module acsm_frame_rx (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // link side
  acsm_link_if.rx lk
);
  import acsm_pkg::*;
  logic [19:0] shift_q;
  logic done_q;
  logic [15:0] tag_q;
  acsm_slot_t s1_q;
  acsm_slot_t s2_q;
  acsm_slot_t s12_q;
  wire [19:0] shift_d;
  assign shift_d = {shift_q[18:0], lk.rx_bit};
  // ==========================================================
  // shift every bit, capture at the ends of the tag and slots 1, 2 and 12
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      shift_q <= 20'h00000;
      done_q <= 1'b0;
      tag_q <= 16'h0000;
      s1_q <= 20'h00000;
      s2_q <= 20'h00000;
      s12_q <= 20'h00000;
    end else if (i_clk_en) begin
      done_q <= lk.rx_fall && lk.rx_pos == `ACSM_S12_LAST;
      if (lk.rx_fall) begin
        shift_q <= shift_d;
        if (lk.rx_pos == `ACSM_TAG_LAST) tag_q <= shift_d[15:0];
        if (lk.rx_pos == `ACSM_S1_LAST) s1_q <= shift_d;
        if (lk.rx_pos == `ACSM_S2_LAST) s2_q <= shift_d;
        if (lk.rx_pos == `ACSM_S12_LAST) s12_q <= shift_d;
      end
    end
  end
  assign lk.rx_done = done_q;
  assign lk.rx_tag = tag_q;
  assign lk.rx_slot1 = s1_q;
  assign lk.rx_slot2 = s2_q;
  assign lk.rx_slot12 = s12_q;
endmodule
`default_nettype wire

/* rtl/acsm_core.sv */
// link status, codec readback, modem slot 12 and queue level registers
// assumes one AHB-Lite slave on the bus (hreadyout drives hready) and a codec driving the link clock
//
// Overview of operation
// - codec-ready bit 24 follows the ready flag of each received frame tag
// - a new codec register read request clears readback-valid bit 23
// - readback-valid sets again when the codec returns read data
// - the echoed register index lands in bits 22-16
// - the latest codec read data is held in bits 15-0
// - a set slot-12 send bit sends the payload in the next frame
// - the slot-12 send bit clears itself at the start of the frame that sends it; writing 0 does nothing
// - the 20-bit outgoing payload is serialised into slot 12
// - the latest valid incoming slot-12 status is kept in bits 19-0
// - an update of the incoming slot-12 status raises an interrupt
// - writing 1 to bit 31 purges the receive queue, self clearing
// - writing 1 to bit 30 purges the transmit queue, self clearing
// - bits 15-8 report bytes held in the receive queue
// - bits 7-0 report free bytes in the transmit queue
// - a set command bit sends address in slot 1 and, for a write only, the write data in slot 2
// - the command direction bit goes out in slot 1, 1 meaning read
//
// Local design decision: register access over AHB-Lite.
`include "acsm_params.svh"
`default_nettype none
module acsm_core (
  // clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire acsm_pkg::acsm_word_t i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // serial link
  input wire logic i_bit_clk,
  input wire logic i_sdata_in,
  output logic o_sync,
  output logic o_sdata_out,
  // queue levels and purge strobes
  input wire logic [7:0] i_rx_fill,
  input wire logic [7:0] i_tx_free,
  output logic o_rx_purge,
  output logic o_tx_purge,
  // interrupt
  output logic o_irq
);
  import acsm_pkg::*;

  acsm_link_if lk();

  // ==========================================================
  // link pin synchronisers and edge detect
  logic [2:0] bclk_q;
  logic [1:0] sdin_q;
  logic [7:0] pos_q;
  wire bit_rise;
  wire bit_fall;
  wire [7:0] pos_next;
  wire frame_start;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      bclk_q <= 3'h0;
      sdin_q <= 2'h0;
    end else if (i_clk_en) begin
      bclk_q <= {bclk_q[1:0], i_bit_clk};
      sdin_q <= {sdin_q[0], i_sdata_in};
    end
  end
  assign bit_rise = bclk_q[1] & ~bclk_q[2];
  assign bit_fall = ~bclk_q[1] & bclk_q[2];
  assign pos_next = pos_q + 8'd1;
  assign frame_start = bit_rise && pos_next == 8'h00;

  // ==========================================================
  // bus slave
  acsm_bus_state_t bus_q;
  logic [7:0] addr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  wire accept;
  wire wr_en;
  wire wr_cmd;
  wire wr_mctl;
  wire wr_level;
  wire wr_int_st;
  wire wr_int_msk;
  assign accept = i_hsel & i_htrans[1] & i_hready;
  assign wr_en = bus_q == ACSM_BUS_WRITE && i_hready;
  assign wr_cmd = wr_en && addr_q == `ACSM_OFS_CMD;
  assign wr_mctl = wr_en && addr_q == `ACSM_OFS_MCTL;
  assign wr_level = wr_en && addr_q == `ACSM_OFS_LEVEL;
  assign wr_int_st = wr_en && addr_q == `ACSM_OFS_INT_ST;
  assign wr_int_msk = wr_en && addr_q == `ACSM_OFS_INT_MSK;
  // reads take one wait state so a write just before is seen
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      bus_q <= ACSM_BUS_IDLE;
      addr_q <= 8'h00;
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else if (i_clk_en) begin
      unique case (bus_q)
        ACSM_BUS_READ: begin
          hrdata_q <= rd_mux;
          hready_q <= 1'b1;
          bus_q <= ACSM_BUS_IDLE;
        end
        ACSM_BUS_IDLE, ACSM_BUS_WRITE: begin
          if (accept) begin
            addr_q <= i_haddr[7:0];
            hready_q <= i_hwrite;
            bus_q <= i_hwrite ? ACSM_BUS_WRITE : ACSM_BUS_READ;
          end else begin
            bus_q <= ACSM_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // command and modem control registers
  logic cmd_go_q;
  logic cmd_rw_q;
  logic [6:0] cmd_index_q;
  logic [15:0] cmd_wdata_q;
  logic modem_go_q;
  acsm_slot_t modem_out_q;
  logic frm_cmd_q;
  logic frm_rw_q;
  logic [6:0] frm_index_q;
  logic [15:0] frm_wdata_q;
  logic frm_modem_q;
  acsm_slot_t frm_payload_q;
  wire cmd_set;
  wire modem_set;
  assign cmd_set = wr_cmd & i_hwdata[`ACSM_CMD_GO_BIT];
  assign modem_set = wr_mctl & i_hwdata[`ACSM_MCTL_GO_BIT];
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cmd_go_q <= 1'b0;
      cmd_rw_q <= 1'b0;
      cmd_index_q <= 7'h00;
      cmd_wdata_q <= 16'h0000;
      modem_go_q <= 1'b0;
      modem_out_q <= 20'h00000;
    end else if (i_clk_en) begin
      if (wr_cmd) begin
        cmd_rw_q <= i_hwdata[`ACSM_CMD_RW_BIT];
        cmd_index_q <= i_hwdata[6:0];
        cmd_wdata_q <= i_hwdata[23:8];
      end
      if (wr_mctl) modem_out_q <= i_hwdata[19:0];
      // a request written in the frame-start cycle waits for the next frame
      cmd_go_q <= cmd_set | (cmd_go_q & ~frame_start);
      modem_go_q <= modem_set | (modem_go_q & ~frame_start);
    end
  end
  // frame content is frozen at frame start
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      frm_cmd_q <= 1'b0;
      frm_rw_q <= 1'b0;
      frm_index_q <= 7'h00;
      frm_wdata_q <= 16'h0000;
      frm_modem_q <= 1'b0;
      frm_payload_q <= 20'h00000;
    end else if (i_clk_en && frame_start) begin
      frm_cmd_q <= cmd_go_q;
      frm_rw_q <= cmd_rw_q;
      frm_index_q <= cmd_index_q;
      frm_wdata_q <= cmd_wdata_q;
      frm_modem_q <= modem_go_q;
      frm_payload_q <= modem_out_q;
    end
  end

  // ==========================================================
  // serial framing
  logic sync_q;
  logic sdout_q;
  assign lk.tx_pos = pos_next;
  assign lk.tx_cmd_go = frame_start ? cmd_go_q : frm_cmd_q;
  assign lk.tx_rw = frame_start ? cmd_rw_q : frm_rw_q;
  assign lk.tx_index = frame_start ? cmd_index_q : frm_index_q;
  assign lk.tx_wdata = frame_start ? cmd_wdata_q : frm_wdata_q;
  assign lk.tx_modem_go = frame_start ? modem_go_q : frm_modem_q;
  assign lk.tx_modem = frame_start ? modem_out_q : frm_payload_q;
  // codec answers one bit later than our own position
  assign lk.rx_fall = bit_fall;
  assign lk.rx_pos = pos_q - 8'd1;
  assign lk.rx_bit = sdin_q[1];
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pos_q <= `ACSM_POS_RST;
      sync_q <= 1'b0;
      sdout_q <= 1'b0;
    end else if (i_clk_en && bit_rise) begin
      pos_q <= pos_next;
      sync_q <= pos_next <= `ACSM_TAG_LAST;
      sdout_q <= lk.tx_bit;
    end
  end
  acsm_frame_tx u_tx (
    .lk(lk.tx)
  );
  acsm_frame_rx u_rx (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .lk(lk.rx)
  );

  // ==========================================================
  // received status and readback
  logic ready_q;
  logic rb_wait_q;
  logic rb_arm_q;
  logic rbv_q;
  logic [6:0] echo_q;
  logic [15:0] rdata_q;
  acsm_slot_t mstat_q;
  wire rd_req;
  wire rb_set;
  wire mstat_upd;
  assign rd_req = cmd_set & i_hwdata[`ACSM_CMD_RW_BIT];
  assign rb_set = lk.rx_done & rb_wait_q & lk.rx_tag[`ACSM_TAG_S1_BIT] & lk.rx_tag[`ACSM_TAG_S2_BIT];
  assign mstat_upd = lk.rx_done & lk.rx_tag[`ACSM_TAG_S12_BIT];
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ready_q <= 1'b0;
      rb_wait_q <= 1'b0;
      rb_arm_q <= 1'b0;
      rbv_q <= 1'b0;
      echo_q <= 7'h00;
      rdata_q <= 16'h0000;
      mstat_q <= 20'h00000;
    end else if (i_clk_en) begin
      if (lk.rx_done) ready_q <= lk.rx_tag[`ACSM_TAG_READY_BIT];
      // frame ending just after the request went out is stale, skip it
      rb_arm_q <= (frame_start & cmd_go_q & cmd_rw_q) | (rb_arm_q & ~lk.rx_done);
      rb_wait_q <= (rb_arm_q & lk.rx_done) | (rb_wait_q & ~rb_set);
      rbv_q <= rb_set | (rbv_q & ~rd_req);
      if (rb_set) begin
        echo_q <= lk.rx_slot1[18:12];
        rdata_q <= lk.rx_slot2[19:4];
      end
      if (mstat_upd) mstat_q <= lk.rx_slot12;
    end
  end

  // ==========================================================
  // queue levels and purge
  logic [7:0] rx_fill_q;
  logic [7:0] tx_free_q;
  logic rx_purge_q;
  logic tx_purge_q;
  wire rx_purge_d;
  wire tx_purge_d;
  assign rx_purge_d = wr_level & i_hwdata[`ACSM_LVL_RX_PURGE_BIT];
  assign tx_purge_d = wr_level & i_hwdata[`ACSM_LVL_TX_PURGE_BIT];
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rx_fill_q <= `ACSM_RX_FILL_RST;
      tx_free_q <= `ACSM_TX_FREE_RST;
      rx_purge_q <= 1'b0;
      tx_purge_q <= 1'b0;
    end else if (i_clk_en) begin
      rx_purge_q <= rx_purge_d;
      tx_purge_q <= tx_purge_d;
      rx_fill_q <= (rx_purge_d | rx_purge_q) ? `ACSM_RX_FILL_RST : i_rx_fill;
      tx_free_q <= (tx_purge_d | tx_purge_q) ? `ACSM_TX_FREE_RST : i_tx_free;
    end
  end

  // ==========================================================
  // interrupts: sticky status, write one to clear, set wins
  acsm_irq_t int_st_q;
  acsm_irq_t int_msk_q;
  logic irq_q;
  wire [2:0] int_ev;
  wire [2:0] int_st_d;
  wire [2:0] int_msk_d;
  assign int_ev = {lk.rx_done & (ready_q != lk.rx_tag[`ACSM_TAG_READY_BIT]), rb_set, mstat_upd};
  assign int_st_d = int_ev | (int_st_q & ~({3{wr_int_st}} & i_hwdata[2:0]));
  assign int_msk_d = wr_int_msk ? i_hwdata[2:0] : int_msk_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      int_st_q <= 3'h0;
      int_msk_q <= 3'h0;
      irq_q <= 1'b0;
    end else if (i_clk_en) begin
      int_st_q <= int_st_d;
      int_msk_q <= int_msk_d;
      irq_q <= |(int_st_d & int_msk_d);
    end
  end

  // ==========================================================
  // read data selection
  always_comb begin
    unique case (addr_q)
      `ACSM_OFS_CMD: rd_mux = {7'h00, cmd_go_q, cmd_wdata_q, cmd_rw_q, cmd_index_q};
      `ACSM_OFS_STAT: rd_mux = {7'h00, ready_q, rbv_q, echo_q, rdata_q};
      `ACSM_OFS_MCTL: rd_mux = {11'h000, modem_go_q, modem_out_q};
      `ACSM_OFS_MSTAT: rd_mux = {12'h000, mstat_q};
      `ACSM_OFS_LEVEL: rd_mux = {16'h0000, rx_fill_q, tx_free_q};
      `ACSM_OFS_INT_ST: rd_mux = {29'h00000000, int_st_q};
      `ACSM_OFS_INT_MSK: rd_mux = {29'h00000000, int_msk_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  assign o_hrdata = hrdata_q;
  assign o_hreadyout = hready_q;
  assign o_hresp = 1'b0;
  assign o_sync = sync_q;
  assign o_sdata_out = sdout_q;
  assign o_rx_purge = rx_purge_q;
  assign o_tx_purge = tx_purge_q;
  assign o_irq = irq_q;

  // ==========================================================
  // checks
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_ready_follows: assert property (i_clk_en && lk.rx_done |=> ready_q == $past(lk.rx_tag[15]))
    else $error("codec ready not taken from frame tag");
  a_read_clears_valid: assert property (i_clk_en && rd_req && !rb_set |=> !rbv_q)
    else $error("readback valid not cleared by read request");
  a_valid_on_return: assert property (i_clk_en && rb_set |=> rbv_q && echo_q == $past(lk.rx_slot1[18:12]))
    else $error("readback valid or index not captured");
  a_data_on_return: assert property (i_clk_en && rb_set |=> rdata_q == $past(lk.rx_slot2[19:4]))
    else $error("readback data not captured");
  a_modem_selfclear: assert property (i_clk_en && frame_start && modem_go_q && !modem_set |=> !modem_go_q && frm_modem_q)
    else $error("slot 12 send bit not consumed at frame start");
  a_modem_first_bit: assert property (i_clk_en && bit_rise && pos_next == 8'd236 && frm_modem_q
    |=> o_sdata_out == $past(frm_payload_q[19]))
    else $error("slot 12 first bit wrong");
  a_rw_bit_out: assert property (i_clk_en && bit_rise && pos_next == 8'd16 && frm_cmd_q
    |=> o_sdata_out == $past(frm_rw_q))
    else $error("slot 1 direction bit wrong");
  a_mstat_irq: assert property (i_clk_en && mstat_upd |=> int_st_q[0] && mstat_q == $past(lk.rx_slot12))
    else $error("modem status update not flagged");
  a_rx_purge: assert property (i_clk_en && rx_purge_d |=> o_rx_purge && rx_fill_q == 8'h00)
    else $error("receive purge not applied");
  a_tx_purge: assert property (i_clk_en && tx_purge_d |=> o_tx_purge && tx_free_q == 8'h80)
    else $error("transmit purge not applied");
endmodule
`default_nettype wire

/* testbench/acsm_codec_model.sv */
// codec model: makes the bit clock, sends frames, captures controller frames
// assumes i_frame holds tag, slots 1, 2 and 12 MSB first in bits 255..0
`default_nettype none
module acsm_codec_model (
  // control from the bench
  input wire logic i_run,
  input wire logic [255:0] i_frame,
  // serial link
  input wire logic i_sdata_out,
  input wire logic i_sync,
  output logic o_bit_clk,
  output logic o_sdata_in,
  // captured controller frames
  output var int o_frames,
  output var int o_s12_cnt,
  output var int o_sync_err,
  output logic [255:0] o_cmd_frame,
  output logic [255:0] o_s12_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  int r;
  logic [255:0] cap;
  // ==========================================================
  // bit clock and serial data
  initial begin
    o_bit_clk = 1'b0;
    o_sdata_in = 1'b0;
    o_frames = 0;
    o_s12_cnt = 0;
    o_sync_err = 0;
    o_cmd_frame = '0;
    o_s12_frame = '0;
    cap = '0;
    r = 0;
    wait (i_run === 1'b1);
    // off the system clock grid
    #1.3;
    forever begin
      o_bit_clk = 1'b1;
      // codec output lags the controller by one bit
      o_sdata_in = i_frame[255 - ((r + 255) % 256)];
      #40;
      o_bit_clk = 1'b0;
      cap[255 - (r % 256)] = i_sdata_out;
      // sync high over the tag positions only
      if (i_sync !== (r % 256 < 16)) o_sync_err++;
      if (r % 256 == 255) begin
        o_frames++;
        if (cap[243]) begin
          o_s12_cnt++;
          o_s12_frame = cap;
        end
        if (cap[254]) o_cmd_frame = cap;
      end
      r++;
      #40;
    end
  end
endmodule
`default_nettype wire

/* testbench/test_acsm_core.sv */
// bench for the link status, modem slot and queue level block
// assumes acsm_core alone on an AHB-Lite bus and the codec model on the link
`include "acsm_params.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_acsm_core;
  timeunit 1ns;
  timeprecision 1ps;
  import acsm_pkg::*;
  logic clk, rst_n, hsel, hwrite, hready, hresp, bit_clk, sdi, sync, sdo, rxp_s, txp_s, irq, run;
  logic [31:0] haddr, hrdata;
  logic [1:0] htrans;
  acsm_word_t hwdata, rd;
  logic [7:0] rx_fill, tx_free;
  logic [255:0] frame, cmd_f, s12_f;
  int frames, s12_cnt, sync_err, rxp, txp, cyc, num_errors, checks_done, n0;
  // ==========================================================
  // design and codec
  acsm_core u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hready(hready), .i_hwdata(hwdata),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_bit_clk(bit_clk), .i_sdata_in(sdi),
    .o_sync(sync), .o_sdata_out(sdo), .i_rx_fill(rx_fill), .i_tx_free(tx_free), .o_rx_purge(rxp_s),
    .o_tx_purge(txp_s), .o_irq(irq));
  acsm_codec_model u_codec (.i_run(run), .i_frame(frame), .i_sdata_out(sdo), .i_sync(sync), .o_bit_clk(bit_clk),
    .o_sdata_in(sdi), .o_frames(frames), .o_s12_cnt(s12_cnt), .o_sync_err(sync_err), .o_cmd_frame(cmd_f),
    .o_s12_frame(s12_f));
  // ==========================================================
  // clock, queue model, timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rxp_s === 1'b1) begin
      rxp <= rxp + 1;
      rx_fill <= 8'h00;
    end
    if (txp_s === 1'b1) begin
      txp <= txp + 1;
      tx_free <= 8'h80;
    end
    if (cyc == 85000) begin
      num_errors++;
      summarize();
    end
  end
  // ==========================================================
  // tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input acsm_word_t wd, output acsm_word_t d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input acsm_word_t wd);
    acsm_word_t d;
    bus(a, 1'b1, wd, d);
  endtask
  task automatic chk_rd(input logic [7:0] a, input acsm_word_t e, input string nm);
    bus(a, 1'b0, 32'h0, rd);
    `CHK(nm, e, rd)
  endtask
  task automatic wait_frames(input int n);
    int f;
    f = frames + n;
    while (frames < f) @(posedge clk);
  endtask
  function automatic logic [255:0] mk(input logic [15:0] t, input logic [19:0] s1, s2, s12);
    return {t, s1, s2, 180'h0, s12};
  endfunction
  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    rx_fill = 8'h00;
    tx_free = 8'h80;
    frame = '0;
    run = 1'b0;
    {num_errors, checks_done, cyc, rxp, txp} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd(`ACSM_OFS_STAT, 32'h0, "stat_rst");
    chk_rd(`ACSM_OFS_MCTL, 32'h0, "mctl_rst");
    chk_rd(`ACSM_OFS_MSTAT, 32'h0, "mstat_rst");
    chk_rd(`ACSM_OFS_LEVEL, 32'h80, "level_rst");
    wr(`ACSM_OFS_STAT, 32'hffffffff);
    chk_rd(`ACSM_OFS_STAT, 32'h0, "stat_ro");
    `CHK("hresp", 1'b0, hresp)
    chk_rd(8'h44, 32'h0, "unmapped");
    $display("test reset done");
    rx_fill <= 8'h12;
    tx_free <= 8'h34;
    chk_rd(`ACSM_OFS_LEVEL, 32'h1234, "levels");
    wr(`ACSM_OFS_LEVEL, 32'h80000000);
    repeat (4) @(posedge clk);
    `CHK("rx_purge", 2'b10, {rxp[0], txp[0]})
    wr(`ACSM_OFS_LEVEL, 32'h40000000);
    repeat (4) @(posedge clk);
    `CHK("tx_purge", 32'd1, txp)
    chk_rd(`ACSM_OFS_LEVEL, 32'h80, "level_purged");
    $display("test levels done");
    run <= 1'b1;
    frame <= mk(16'h8008, 20'h0, 20'h0, 20'habcde);
    wr(`ACSM_OFS_INT_MSK, 32'h1);
    wait_frames(2);
    `CHK("irq_s12", 1'b1, irq)
    chk_rd(`ACSM_OFS_MSTAT, 32'habcde, "mstat");
    chk_rd(`ACSM_OFS_STAT, 32'h01000000, "ready_set");
    frame <= '0;
    wait_frames(2);
    wr(`ACSM_OFS_INT_ST, 32'h7);
    repeat (2) @(posedge clk);
    `CHK("irq_clear", 1'b0, irq)
    chk_rd(`ACSM_OFS_INT_ST, 32'h0, "int_st");
    chk_rd(`ACSM_OFS_STAT, 32'h0, "ready_drop");
    $display("test irq done");
    frame <= mk(16'h8000, 20'h0, 20'h0, 20'h0);
    n0 = s12_cnt;
    wr(`ACSM_OFS_MCTL, 32'h0015a5a5);
    wait_frames(2);
    chk_rd(`ACSM_OFS_STAT, 32'h01000000, "ready_again");
    `CHK("s12_sent", n0 + 1, s12_cnt)
    `CHK("s12_data", 20'h5a5a5, s12_f[19:0])
    chk_rd(`ACSM_OFS_MCTL, 32'h0005a5a5, "mctl_clr");
    wr(`ACSM_OFS_MCTL, 32'h0005a5a5);
    $display("test modem done");
    wr(`ACSM_OFS_CMD, 32'h01135705);
    wait_frames(2);
    `CHK("wcmd_tag", 3'b111, cmd_f[255:253])
    `CHK("wcmd_s1", 20'h05000, cmd_f[239:220])
    `CHK("wcmd_s2", 20'h13570, cmd_f[219:200])
    wr(`ACSM_OFS_CMD, 32'h01000095);
    wait_frames(2);
    `CHK("rcmd_tag", 3'b110, cmd_f[255:253])
    `CHK("rcmd_s1", 20'h95000, cmd_f[239:220])
    frame <= mk(16'he000, 20'h15000, 20'hbeef0, 20'h0);
    wait_frames(2);
    chk_rd(`ACSM_OFS_STAT, 32'h0195beef, "readback");
    frame <= mk(16'h8000, 20'h0, 20'h0, 20'h0);
    wr(`ACSM_OFS_CMD, 32'h010000a2);
    bus(`ACSM_OFS_STAT, 1'b0, 32'h0, rd);
    `CHK("valid_clr", 1'b0, rd[23])
    `CHK("s12_once", n0 + 1, s12_cnt)
    `CHK("sync", 32'd0, sync_err)
    $display("test command done");
    summarize();
  end
endmodule
`default_nettype wire
